// File: rtl/apsp_fifo.sv
/*
  synchronous word fifo with valid/ready on both sides; read data come
  from a register. assumes one clock and an active-high async reset.
*/
`timescale 1ns/10ps
module apsp_fifo #(
  parameter int unsigned WIDTH = 10,
  parameter int unsigned DEPTH = 16
) (
  // clock and reset
  input  wire logic                     clk_i,
  input  wire logic                     sys_rst_i,
  // fill side
  input  wire logic                     in_valid_i,
  input  wire logic [WIDTH-1:0]         in_data_i,
  output logic                          in_ready_o,
  // drain side
  output logic                          out_valid_o,
  output logic [WIDTH-1:0]              out_data_o,
  input  wire logic                     out_ready_i,
  // fill level
  output logic [$clog2(DEPTH+1)-1:0]    level_o
);
  localparam int unsigned AW = $clog2(DEPTH);
  localparam int unsigned LW = $clog2(DEPTH+1);

  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
      $error("fifo depth must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [LW-1:0]    count_r;
  logic             push;
  logic             pop;

  // handshakes; a full fifo refuses, an empty one shows nothing
  assign in_ready_o  = (count_r != LW'(DEPTH));
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;
  assign level_o     = count_r;

  // storage array
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data_i;
    end
  end

  // pointers and count
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + AW'(1);
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + AW'(1);
      end
      if (push && !pop) begin
        count_r <= count_r + LW'(1);
      end else if (pop && !push) begin
        count_r <= count_r - LW'(1);
      end
    end
  end

  // registered head word; out_valid tracks a non-empty store
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      out_valid_o <= 1'b0;
      out_data_o  <= '0;
    end else begin
      out_valid_o <= 1'b0;
      if (count_r > LW'(1) || (count_r == LW'(1) && !pop)) begin
        out_valid_o <= 1'b1;
        out_data_o  <= pop ? mem_r[rd_ptr_r + AW'(1)] : mem_r[rd_ptr_r];
      end
    end
  end
endmodule

// File: rtl/apsp_pkg.sv
/*
  shared constants for the parallel sample port: widths, latency,
  register offsets, field positions and reset values.
  assumes a 32-bit AXI4-Lite register bus and a single 50 MHz clock.
*/
package apsp_pkg;
  localparam int unsigned SAMPLE_W      = 10;
  localparam int unsigned LATENCY_CYC   = 5;
  localparam int unsigned FIFO_DEPTH    = 16;
  localparam int unsigned CLK_PERIOD_NS = 20;
  // register byte offsets
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] DATA_OFS   = 8'h08;
  localparam logic [7:0] COUNT_OFS  = 8'h0C;
  // control fields
  localparam int unsigned CTRL_OE_N_BIT   = 0;
  localparam int unsigned CTRL_SLEEP_BIT  = 1;
  localparam int unsigned CTRL_SPAN_BIT   = 2;
  localparam int unsigned CTRL_REFSEL_BIT = 3;
  localparam int unsigned CTRL_W          = 4;
  // control reset: output enable low (pull-down), others low
  localparam logic [3:0]  CTRL_RESET      = 4'h0;
  // status fields
  localparam int unsigned STAT_EMPTY_BIT  = 0;
  localparam int unsigned STAT_FULL_BIT   = 1;
  localparam int unsigned STAT_SLEEP_BIT  = 2;
  localparam int unsigned STAT_LEVEL_LSB  = 8;
  // data register: valid flag position
  localparam int unsigned DATA_VALID_BIT  = 31;
  // axi responses
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;
endpackage

// File: rtl/apsp_top.sv
/*
  digital side of a 10-bit pipelined sampling converter: quantised samples
  pass a fixed 5-cycle pipeline to a tri-stateable parallel bus, and are
  also buffered for software over AXI4-Lite. static controls (output
  enable, sleep, span, reference) come from a control register.
  assumes the convert clock is clk_i and the bus runs on the same clock.
*/
// Local design decisions: register access over AXI4-Lite and the register offsets.
// Summary of operation
// - samples are straight offset binary, unsigned
// - first output line carries the msb
// - output enable high tri-states data lines
// - output enable defaults low, bus driven
// - sleep high stops conversion, saves power
// - span select high 2Vp-p, low 1Vp-p
// - reference select high external, low internal
// - word appears five cycles after sampling
// - output word changes on rising clock edge
`timescale 1ns/10ps
module apsp_top #(
  parameter int unsigned SAMPLE_W = apsp_pkg::SAMPLE_W,
  parameter int unsigned LATENCY  = apsp_pkg::LATENCY_CYC
) (
  // clock and reset
  input  wire logic                clk_i,
  input  wire logic                sys_rst_i,
  // quantiser result, taken on each rising edge
  input  wire logic [SAMPLE_W-1:0] quant_i,
  // parallel sample bus, line 1 first
  output logic [SAMPLE_W-1:0]      data_line_o,
  output logic [SAMPLE_W-1:0]      data_line_oe_o,
  output logic                     data_new_o,
  // analog-side controls
  output logic                     sleep_request_o,
  output logic                     span_select_o,
  output logic                     reference_source_select_o,
  // axi4-lite write address and data
  input  wire logic [7:0]          s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  // axi4-lite write response
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]          s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready
);
  localparam int unsigned LW = $clog2(apsp_pkg::FIFO_DEPTH + 1);

  initial begin
    if (SAMPLE_W < 1 || SAMPLE_W > 30)
      $error("sample width must be 1 to 30");
    if (LATENCY < 2)
      $error("latency must be at least 2");
  end

  // reverse bit order so index 0 of the line bus is the msb
  function automatic logic [SAMPLE_W-1:0] msb_first(input logic [SAMPLE_W-1:0] w);
    logic [SAMPLE_W-1:0] r;
    r = '0;
    for (int i = 0; i < SAMPLE_W; i++) begin
      r[i] = w[SAMPLE_W-1-i];
    end
    return r;
  endfunction

  // register address decode, shared by read and write paths
  function automatic logic is_mapped(input logic [7:0] a);
    return (a == apsp_pkg::CTRL_OFS) || (a == apsp_pkg::STATUS_OFS) ||
           (a == apsp_pkg::DATA_OFS) || (a == apsp_pkg::COUNT_OFS);
  endfunction

  logic [apsp_pkg::CTRL_W-1:0] ctrl_r;
  logic [SAMPLE_W-1:0]         pipe_r [LATENCY];
  logic [LATENCY-1:0]          pvld_r;
  logic [31:0]                 count_r;
  logic                        fifo_in_ready;
  logic                        fifo_out_valid;
  logic [SAMPLE_W-1:0]         fifo_out_data;
  logic                        fifo_pop;
  logic [LW-1:0]               fifo_level;
  logic                        aw_held_r;
  logic                        w_held_r;
  logic [7:0]                  aw_addr_r;
  logic [31:0]                 w_data_r;
  logic [3:0]                  w_strb_r;
  logic                        do_write;
  logic                        do_read;
  logic [31:0]                 rd_word;

  // conversion pipeline; sleep stops new samples entering
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pvld_r <= '0;
    end else begin
      pvld_r <= {pvld_r[LATENCY-2:0], !ctrl_r[apsp_pkg::CTRL_SLEEP_BIT]};
    end
  end

  // sample words, straight offset binary passed unchanged
  always_ff @(posedge clk_i) begin
    pipe_r[0] <= quant_i;
    for (int i = 1; i < LATENCY; i++) begin
      pipe_r[i] <= pipe_r[i-1];
    end
  end

  // output bus updates on the rising edge, five edges after sampling
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      data_line_o <= '0;
      data_new_o  <= 1'b0;
    end else begin
      data_new_o <= pvld_r[LATENCY-1];
      if (pvld_r[LATENCY-1]) begin
        data_line_o <= msb_first(pipe_r[LATENCY-1]);
      end
    end
  end

  // drive enable follows the inverted output-enable control
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      data_line_oe_o <= '1;
    end else begin
      data_line_oe_o <= {SAMPLE_W{!ctrl_r[apsp_pkg::CTRL_OE_N_BIT]}};
    end
  end

  // analog controls mirror the control register
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sleep_request_o           <= 1'b0;
      span_select_o             <= 1'b0;
      reference_source_select_o <= 1'b0;
    end else begin
      sleep_request_o           <= ctrl_r[apsp_pkg::CTRL_SLEEP_BIT];
      span_select_o             <= ctrl_r[apsp_pkg::CTRL_SPAN_BIT];
      reference_source_select_o <= ctrl_r[apsp_pkg::CTRL_REFSEL_BIT];
    end
  end

  // delivered-word counter for software
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      count_r <= '0;
    end else if (do_write && aw_addr_r == apsp_pkg::COUNT_OFS) begin
      count_r <= '0;
    end else if (pvld_r[LATENCY-1]) begin
      count_r <= count_r + 32'h1;
    end
  end

  // software buffer; words arriving while full are dropped
  apsp_fifo #(
    .WIDTH (SAMPLE_W),
    .DEPTH (apsp_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .sys_rst_i   (sys_rst_i),
    .in_valid_i  (pvld_r[LATENCY-1]),
    .in_data_i   (pipe_r[LATENCY-1]),
    .in_ready_o  (fifo_in_ready),
    .out_valid_o (fifo_out_valid),
    .out_data_o  (fifo_out_data),
    .out_ready_i (fifo_pop),
    .level_o     (fifo_level)
  );

  // write channel capture, address and data in either order
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      aw_addr_r <= '0;
      w_data_r  <= '0;
      w_strb_r  <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held_r <= 1'b0;
        w_held_r  <= 1'b0;
      end
    end
  end

  assign do_write = aw_held_r && w_held_r && !s_axi_bvalid;
  assign do_read  = s_axi_arvalid && s_axi_arready;
  assign fifo_pop = do_read && s_axi_araddr == apsp_pkg::DATA_OFS && fifo_out_valid;

  // ready flags: one-cycle accept pulses when idle
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held_r && !s_axi_awready && s_axi_awvalid && !s_axi_bvalid;
      s_axi_wready  <= !w_held_r && !s_axi_wready && s_axi_wvalid && !s_axi_bvalid;
      s_axi_arready <= !s_axi_arready && s_axi_arvalid && !s_axi_rvalid;
    end
  end

  // control register, byte lane 0 only
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ctrl_r <= apsp_pkg::CTRL_RESET;
    end else if (do_write && aw_addr_r == apsp_pkg::CTRL_OFS && w_strb_r[0]) begin
      ctrl_r <= w_data_r[apsp_pkg::CTRL_W-1:0];
    end
  end

  // write response
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= apsp_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= is_mapped(aw_addr_r) ? apsp_pkg::RESP_OKAY : apsp_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // read mux
  always_comb begin
    rd_word = '0;
    unique case (s_axi_araddr)
      apsp_pkg::CTRL_OFS: begin
        rd_word[apsp_pkg::CTRL_W-1:0] = ctrl_r;
      end
      apsp_pkg::STATUS_OFS: begin
        rd_word[apsp_pkg::STAT_EMPTY_BIT] = !fifo_out_valid;
        rd_word[apsp_pkg::STAT_FULL_BIT]  = !fifo_in_ready;
        rd_word[apsp_pkg::STAT_SLEEP_BIT] = ctrl_r[apsp_pkg::CTRL_SLEEP_BIT];
        rd_word[apsp_pkg::STAT_LEVEL_LSB +: LW] = fifo_level;
      end
      apsp_pkg::DATA_OFS: begin
        rd_word[SAMPLE_W-1:0]             = fifo_out_data;
        rd_word[apsp_pkg::DATA_VALID_BIT] = fifo_out_valid;
      end
      apsp_pkg::COUNT_OFS: begin
        rd_word = count_r;
      end
      default: begin
        rd_word = '0;
      end
    endcase
  end

  // read response
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= apsp_pkg::RESP_OKAY;
    end else if (do_read) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= is_mapped(s_axi_araddr) ? apsp_pkg::RESP_OKAY : apsp_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // assertions
  latency_word_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !ctrl_r[apsp_pkg::CTRL_SLEEP_BIT] ##1 pvld_r[0] |-> ##5 data_new_o)
    else $error("word not delivered after five cycles");

  msb_order_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    pvld_r[0] ##5 data_new_o |-> data_line_o[0] == $past(quant_i[SAMPLE_W-1], 6))
    else $error("first line does not carry the msb");

  offset_bin_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    data_new_o |-> msb_first(data_line_o) == $past(quant_i, 6))
    else $error("output word not straight binary of the sample");

  tristate_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ctrl_r[apsp_pkg::CTRL_OE_N_BIT] |=> data_line_oe_o == '0)
    else $error("data lines driven while output enable high");

  drive_on_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !ctrl_r[apsp_pkg::CTRL_OE_N_BIT] |=> data_line_oe_o == '1)
    else $error("data lines not driven while output enable low");

  sleep_stop_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ctrl_r[apsp_pkg::CTRL_SLEEP_BIT] [*7] |-> !data_new_o && sleep_request_o)
    else $error("words still delivered in sleep");

  span_pin_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    span_select_o == $past(ctrl_r[apsp_pkg::CTRL_SPAN_BIT]))
    else $error("span select does not follow control");

  ref_pin_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    reference_source_select_o == $past(ctrl_r[apsp_pkg::CTRL_REFSEL_BIT]))
    else $error("reference select does not follow control");

  edge_hold_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !data_new_o |-> $stable(data_line_o))
    else $error("output word changed without a new sample");
endmodule

// File: verification/apsp_cap_model.sv
/*
  capture-side model of the sample port: resolves the bus lines and
  latches one word per new-word pulse while all ten lines are driven.
  assumes per-line drive enables, high while the port drives a line.
*/
`timescale 1ns/10ps
module apsp_cap_model (
  // clock
  input  wire logic       clk_i,
  // sample bus from the port
  input  wire logic [9:0] line_i,
  input  wire logic [9:0] line_oe_i,
  input  wire logic       new_i,
  // captured words
  output logic [9:0]      word_o,
  output logic [31:0]     count_o
);
  logic [9:0] bus_w;
  logic [9:0] last_r;

  initial begin
    last_r  = 10'h000;
    word_o  = 10'h000;
    count_o = 0;
  end

  // a released line shows the inverse of its last level, never a stale value
  always_comb begin
    for (int i = 0; i < 10; i++) begin
      bus_w[i] = line_oe_i[i] ? line_i[i] : ~last_r[i];
    end
  end

  // remember the wire levels
  always @(posedge clk_i) begin
    last_r <= bus_w;
  end

  // one word per rising edge with a new word, bus ignored while released
  always @(posedge clk_i) begin
    if (new_i && (&line_oe_i)) begin
      word_o  <= bus_w;
      count_o <= count_o + 1;
    end
  end
endmodule

// File: verification/tb_adc_parallel_sample_port.sv
/*
  testbench of the parallel sample port: ramps the quantiser input,
  checks latency and bit order, drives controls and the buffer over
  AXI4-Lite. assumes apsp_top and apsp_pkg as delivered.
*/
`timescale 1ns/10ps
module tb_adc_parallel_sample_port;
  logic        clk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic [9:0]  quant_i = 10'h000;
  logic [9:0]  data_line_o;
  logic [9:0]  data_line_oe_o;
  logic        data_new_o;
  logic        sleep_request_o;
  logic        span_select_o;
  logic        reference_source_select_o;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready = 1'b0;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready = 1'b0;
  logic [9:0]  cap_word;
  logic [31:0] cap_count;
  logic [31:0] cap_seen = 32'h0;
  logic [9:0]  qh [8];
  int          cyc = 0;
  int          aw_cnt = 0;
  int          tmo = 0;
  int          err_total = 0;
  int          comparisons = 0;

  apsp_top #(.SAMPLE_W(10), .LATENCY(5)) u_apsp_top (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .quant_i(quant_i),
    .data_line_o(data_line_o), .data_line_oe_o(data_line_oe_o),
    .data_new_o(data_new_o), .sleep_request_o(sleep_request_o),
    .span_select_o(span_select_o),
    .reference_source_select_o(reference_source_select_o),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready)
  );

  apsp_cap_model u_apsp_cap_model (
    .clk_i(clk_i), .line_i(data_line_o), .line_oe_i(data_line_oe_o),
    .new_i(data_new_o), .word_o(cap_word), .count_o(cap_count)
  );

  // 50 MHz clock
  always #10 clk_i = ~clk_i;

  // ramp input, step coprime to 1024 so every code passes; track history
  always @(posedge clk_i) begin
    qh[cyc % 8] <= quant_i;
    cyc         <= cyc + 1;
    aw_cnt      <= (!sys_rst_i && !sleep_request_o) ? aw_cnt + 1 : 0;
    quant_i     <= quant_i + 10'h07B;
    cap_seen    <= cap_count;
    tmo         <= tmo + 1;
    if (tmo == 8000) begin
      err_total++;
      stop_test();
    end
  end

  function automatic logic [9:0] msb_first(input logic [9:0] v);
    for (int i = 0; i < 10; i++) begin
      msb_first[i] = v[9-i];
    end
  endfunction

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    comparisons++;
    if (got !== ex) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, ex, got);
    end
  endtask

  // awake for six edges: a word each cycle, sample of five edges earlier
  always @(negedge clk_i) begin
    if (aw_cnt >= 6) begin
      chk("new", 32'h1, {31'h0, data_new_o});
      chk("word", {22'h0, msb_first(qh[(cyc - 6) % 8])}, {22'h0, data_line_o});
    end
    // a capture at this edge took the word launched one edge earlier
    if (aw_cnt >= 7 && cap_count != cap_seen) begin
      chk("cap_word", {22'h0, msb_first(qh[(cyc - 7) % 8])}, {22'h0, cap_word});
    end
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic got;
    got = 1'b0;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!got) begin
      @(posedge clk_i);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        r   = s_axi_bresp;
        got = 1'b1;
      end
    end
    s_axi_bready <= 1'b0;
    @(posedge clk_i); // let an edge pass before the next request
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic got;
    got = 1'b0;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    while (!got) begin
      @(posedge clk_i);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        d   = s_axi_rdata;
        r   = s_axi_rresp;
        got = 1'b1;
      end
    end
    s_axi_rready <= 1'b0;
    @(posedge clk_i); // let an edge pass before the next request
  endtask

  task automatic stop_test;
    if (err_total == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // main sequence
  initial begin
    logic [31:0] d;
    logic [31:0] prev;
    logic [31:0] c0;
    logic [1:0]  r;
    repeat (3) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_i);
    chk("oe_reset", 32'h3FF, {22'h0, data_line_oe_o});
    rd(apsp_pkg::CTRL_OFS, d, r);
    chk("ctrl_reset", 32'h0, d);
    // fill the buffer, then stop conversion and drain it
    repeat (40) @(posedge clk_i);
    rd(apsp_pkg::STATUS_OFS, d, r);
    chk("status_full", 32'h1002, d);
    wr(apsp_pkg::CTRL_OFS, 32'h2, r);
    repeat (10) @(posedge clk_i);
    chk("asleep", 32'h1, {31'h0, sleep_request_o});
    chk("new_asleep", 32'h0, {31'h0, data_new_o});
    rd(apsp_pkg::STATUS_OFS, d, r);
    chk("status_sleep", 32'h1006, d);
    for (int i = 0; i < 16; i++) begin
      rd(apsp_pkg::DATA_OFS, d, r);
      chk("pop_valid", 32'h1, {31'h0, d[apsp_pkg::DATA_VALID_BIT]});
      if (i > 0) chk("pop_step", 32'h7B, (d - prev) & 32'h3FF);
      prev = d;
    end
    rd(apsp_pkg::STATUS_OFS, d, r);
    chk("status_empty", 32'h0005, d);
    rd(apsp_pkg::DATA_OFS, d, r);
    chk("pop_none", 32'h0, {31'h0, d[apsp_pkg::DATA_VALID_BIT]});
    // every control combination, ending awake and driven
    for (int v = 15; v >= 0; v--) begin
      wr(apsp_pkg::CTRL_OFS, 32'(v), r);
      repeat (6) @(posedge clk_i);
      c0 = cap_count;
      chk("oe", {22'h0, {10{~v[0]}}}, {22'h0, data_line_oe_o});
      chk("sleep", 32'(v[1]), {31'h0, sleep_request_o});
      chk("span", 32'(v[2]), {31'h0, span_select_o});
      chk("refsel", 32'(v[3]), {31'h0, reference_source_select_o});
      repeat (8) @(posedge clk_i);
      chk("captures", {31'h0, !v[0] && !v[1]}, {31'h0, cap_count != c0});
      rd(apsp_pkg::CTRL_OFS, d, r);
      chk("ctrl", 32'(v), d);
    end
    // unmapped places answer with an error
    rd(8'h10, d, r);
    chk("rd_unmapped", {30'h0, apsp_pkg::RESP_SLVERR}, {30'h0, r});
    chk("rd_unmapped_data", 32'h0, d);
    wr(8'h14, 32'hFFFF_FFFF, r);
    chk("wr_unmapped", {30'h0, apsp_pkg::RESP_SLVERR}, {30'h0, r});
    // let every code pass the pipeline
    repeat (1100) @(posedge clk_i);
    stop_test();
  end
endmodule
